// ===== rtl/dgc_global_ctrl.sv
// module: distributor global forwarding control and type reporting over ahb-lite
// Contract
// - single-copy/non-secure layout: bit0 off blocks all forwarding, on forwards.
// - with security, non-secure copy bit0 gates only group 1 forwarding.
// - secure/version-two layout: bit1 enables group 1; bits 31..2 reserved.
// - secure/version-two layout: bit0 enables group 0 forwarding, subject to priority.
// - version-one secure copy bit1 aliases non-secure bit0, else reserved.
// - cleared enables never stall other register reads and writes.
// - edges in a disabled group still set pending; fixed by a strap output.
// - version one: software generated pending cleared only on activation.
// - version two: disabled group owns top candidate, nothing is forwarded.
// - version one with security: nothing is forwarded in that case either (our choice).
// - nothing forwardable makes acknowledge reads return the spurious id.
// - type bits 15..11 give lockable count 0..31; reserved without security.
// - type bit 10 reads 1 only when security support exists.
// - type bits 7..5 give cpu interface count minus one; bits 9..8 zero.
// - type bits 4..0 give N, up to 32(N+1) ids capped at 1020.
// - ids 1020..1023 are never forwarded as real interrupts.
// - line-count field also sizes per-interrupt register sets (lines output).
// - implemented ids may be sparse; software probes them.
// - with security, separate secure and non-secure control copies, selected by hnonsec or hprot[3].
// - lockdown input high blocks writes to secure group 0 enable.
// - group 0 fields read zero and ignore non-secure writes.
`timescale 1ns/1ps
module dgc_global_ctrl #(
   parameter bit         VERSION_TWO    = 1'b1,
   parameter bit         SECURITY       = 1'b1,
   parameter bit         V1_ALIAS_BIT1  = 1'b1,
   parameter logic [4:0] LOCKABLE_COUNT = 5'h1F,
   parameter logic [2:0] CPU_COUNT_M1   = 3'h3,
   parameter logic [4:0] LINE_BLOCKS    = 5'h03,
   parameter bit         EDGE_WHEN_OFF  = 1'b1
) (
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [3:0]            hprot,
   input  wire logic                  hnonsec,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire logic                  config_lock_in,
   input  wire dgc_pkg::dgc_cand_t    top_cand,
   output dgc_pkg::dgc_fwd_t          fwd_out,
   output logic                       ack_spurious,
   output logic                       edge_sets_pending_when_off,
   output logic                       sgi_sw_clear_allowed,
   output logic      [4:0]            irq_line_blocks
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic                 group0_forward_en;
      logic                 group1_forward_en;
      dgc_pkg::dgc_aphase_t ap;
      logic [31:0]          rdata;
      dgc_pkg::dgc_fwd_t    fwd;
      logic                 spur;
      logic                 edge_off;
      logic                 sgi_clr;
      logic [4:0]           lines;
   } dgc_state_t;

   dgc_state_t st;
   dgc_state_t next_st;

   // ************************************************************
   // read views
   // ************************************************************
   function automatic logic [31:0] dgc_ctl_view(input logic nonsec, input dgc_state_t s);
      logic [31:0] v;
      v = 32'h0;
      if (!SECURITY) begin
         v[dgc_pkg::CTL_GRP0_BIT] = s.group0_forward_en;
         if (VERSION_TWO)
            v[dgc_pkg::CTL_GRP1_BIT] = s.group1_forward_en;
      end else if (nonsec) begin
         v[dgc_pkg::CTL_GRP0_BIT] = s.group1_forward_en;
      end else begin
         v[dgc_pkg::CTL_GRP0_BIT] = s.group0_forward_en;
         if (VERSION_TWO || V1_ALIAS_BIT1)
            v[dgc_pkg::CTL_GRP1_BIT] = s.group1_forward_en;
      end
      return v;
   endfunction

   function automatic logic [31:0] dgc_type_view();
      logic [31:0] v;
      v = 32'h0;                                                   // upper bits zero
      v[dgc_pkg::TYP_LINES_LSB +: 5] = LINE_BLOCKS;
      v[dgc_pkg::TYP_CPU_LSB +: 3]   = CPU_COUNT_M1;
      v[dgc_pkg::TYP_SEC_BIT]        = SECURITY;
      if (SECURITY)
         v[dgc_pkg::TYP_LOCK_LSB +: 5] = LOCKABLE_COUNT;
      return v;
   endfunction

   // ************************************************************
   // next state
   // ************************************************************
   logic        take;
   logic        grp_on;
   logic        ns_acc;
   logic [31:0] wv;
   logic [9:0]  id_cap;

   always_comb begin
      next_st = st;
      wv      = hwdata;
      ns_acc  = SECURITY && st.ap.nonsec;
      take    = hsel && hready && (htrans == dgc_pkg::HTRANS_NONSEQ ||
                                   htrans == dgc_pkg::HTRANS_SEQ);
      // data phase of the previous access: always zero wait, so a
      // cleared enable can never hold up the bus
      if (st.ap.pend && st.ap.write) begin
         if (st.ap.addr == dgc_pkg::ADDR_FORWARDING_CONTROL) begin
            if (!SECURITY) begin
               next_st.group0_forward_en = wv[dgc_pkg::CTL_GRP0_BIT];
               if (VERSION_TWO)
                  next_st.group1_forward_en = wv[dgc_pkg::CTL_GRP1_BIT];
            end else if (ns_acc) begin
               next_st.group1_forward_en = wv[dgc_pkg::CTL_GRP0_BIT];
            end else begin
               if (!config_lock_in)
                  next_st.group0_forward_en = wv[dgc_pkg::CTL_GRP0_BIT];
               if (VERSION_TWO || V1_ALIAS_BIT1)
                  next_st.group1_forward_en = wv[dgc_pkg::CTL_GRP1_BIT];
            end
         end
         // type and status words ignore writes
      end
      next_st.ap.pend = take;
      if (take) begin
         next_st.ap.write  = hwrite;
         next_st.ap.nonsec = SECURITY ? (hnonsec | hprot[3]) : 1'b0;
         next_st.ap.addr   = haddr[dgc_pkg::ADDR_W-1:0];
         unique case (haddr[dgc_pkg::ADDR_W-1:0])
            dgc_pkg::ADDR_FORWARDING_CONTROL:
               // view after this cycle's write, so a back-to-back read sees it
               next_st.rdata = dgc_ctl_view(SECURITY && (hnonsec | hprot[3]), next_st);
            dgc_pkg::ADDR_CONTROLLER_TYPE_INFO:
               next_st.rdata = dgc_type_view();
            dgc_pkg::ADDR_FORWARD_STATUS:
               next_st.rdata = {30'h0, st.spur, st.fwd.valid};
            default:
               next_st.rdata = 32'h0;
         endcase
      end
      // forwarding decision
      grp_on = top_cand.group1 ? st.group1_forward_en
                               : (st.group0_forward_en && SECURITY) ||
                                 (!SECURITY && st.group0_forward_en);
      if (!SECURITY && !VERSION_TWO)
         grp_on = st.group0_forward_en;
      // candidate of a disabled group blocks both groups in version two;
      // version one blocks the same way with security; without it group0_forward_en alone gates both groups
      id_cap = 10'((32 * (32'(LINE_BLOCKS) + 1)) - 1);
      next_st.fwd.valid = top_cand.valid && grp_on &&
                          top_cand.id < dgc_pkg::FIRST_SPECIAL_ID &&
                          top_cand.id <= id_cap;
      next_st.fwd.group1 = top_cand.group1;
      next_st.fwd.id     = top_cand.id;
      next_st.spur       = !next_st.fwd.valid;
      next_st.edge_off   = EDGE_WHEN_OFF;
      next_st.sgi_clr    = VERSION_TWO;
      next_st.lines      = LINE_BLOCKS;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st <= '0;
         st.group0_forward_en <= dgc_pkg::CTL_RESET;
         st.group1_forward_en <= dgc_pkg::CTL_RESET;
         st.spur              <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   always_comb begin
      hrdata                     = st.rdata;
      hreadyout                  = 1'b1;
      hresp                      = 1'b0;
      fwd_out                    = st.fwd;
      ack_spurious               = st.spur;
      edge_sets_pending_when_off = st.edge_off;
      sgi_sw_clear_allowed       = st.sgi_clr;
      irq_line_blocks            = st.lines;
   end

   // ************************************************************
   // assertions
   // ************************************************************
   property p_fwd_off;
      @(posedge ref_clk) disable iff (sys_rst)
      (!st.group0_forward_en && !st.group1_forward_en) |=> !fwd_out.valid;
   endproperty
   a_fwd_off: assert property (p_fwd_off) else $error("forwarded while disabled");

   property p_g1_gate;
      @(posedge ref_clk) disable iff (sys_rst)
      (top_cand.valid && top_cand.group1 && !st.group1_forward_en) |=> !fwd_out.valid;
   endproperty
   a_g1_gate: assert property (p_g1_gate) else $error("group 1 passed while off");

   property p_g0_gate;
      @(posedge ref_clk) disable iff (sys_rst)
      (top_cand.valid && !top_cand.group1 && !st.group0_forward_en) |=> !fwd_out.valid;
   endproperty
   a_g0_gate: assert property (p_g0_gate) else $error("group 0 passed while off");

   property p_spur;
      @(posedge ref_clk) disable iff (sys_rst) !fwd_out.valid |-> ack_spurious;
   endproperty
   a_spur: assert property (p_spur) else $error("spurious flag missing");

   property p_special;
      @(posedge ref_clk) disable iff (sys_rst)
      fwd_out.valid |-> fwd_out.id < dgc_pkg::FIRST_SPECIAL_ID;
   endproperty
   a_special: assert property (p_special) else $error("special id forwarded");

   sequence s_ctl_write;
      hsel && hready && htrans == dgc_pkg::HTRANS_NONSEQ && hwrite &&
      haddr[11:0] == dgc_pkg::ADDR_FORWARDING_CONTROL && !hnonsec && !hprot[3];
   endsequence
   property p_lock;
      @(posedge ref_clk) disable iff (sys_rst)
      (s_ctl_write ##1 config_lock_in) |=> $stable(st.group0_forward_en);
   endproperty
   a_lock: assert property (p_lock) else $error("locked enable changed");

   property p_type_ro;
      @(posedge ref_clk) disable iff (sys_rst)
      (st.ap.pend && !st.ap.write && st.ap.addr == dgc_pkg::ADDR_CONTROLLER_TYPE_INFO)
      |-> hrdata[15:0] == {SECURITY ? LOCKABLE_COUNT : 5'h0, SECURITY, 2'h0,
                           CPU_COUNT_M1, LINE_BLOCKS} && hrdata[31:16] == 16'h0;
   endproperty
   a_type_ro: assert property (p_type_ro) else $error("type word wrong");

   property p_ready;
      @(posedge ref_clk) disable iff (sys_rst)
      st.ap.pend |-> hreadyout && !hresp;
   endproperty
   a_ready: assert property (p_ready) else $error("bus stalled");

   // ************************************************************
   // control word access checks
   // ************************************************************
   sequence s_ns_ctl_wr;
      st.ap.pend && st.ap.write && st.ap.nonsec &&
      st.ap.addr == dgc_pkg::ADDR_FORWARDING_CONTROL;
   endsequence

   sequence s_sec_ctl_wr;
      st.ap.pend && st.ap.write && !st.ap.nonsec &&
      st.ap.addr == dgc_pkg::ADDR_FORWARDING_CONTROL;
   endsequence

   sequence s_ctl_rd;
      st.ap.pend && !st.ap.write && st.ap.addr == dgc_pkg::ADDR_FORWARDING_CONTROL;
   endsequence

   property p_ns_g1_wr;
      @(posedge ref_clk) disable iff (sys_rst)
      s_ns_ctl_wr |=> st.group1_forward_en == $past(hwdata[dgc_pkg::CTL_GRP0_BIT]);
   endproperty
   a_ns_g1_wr: assert property (p_ns_g1_wr) else $error("ns write lost group 1");

   property p_ns_g0_wi;
      @(posedge ref_clk) disable iff (sys_rst)
      s_ns_ctl_wr |=> $stable(st.group0_forward_en);
   endproperty
   a_ns_g0_wi: assert property (p_ns_g0_wi) else $error("ns write hit group 0");

   property p_sec_g0_wr;
      @(posedge ref_clk) disable iff (sys_rst)
      s_sec_ctl_wr ##0 !config_lock_in
      |=> st.group0_forward_en == $past(hwdata[dgc_pkg::CTL_GRP0_BIT]);
   endproperty
   a_sec_g0_wr: assert property (p_sec_g0_wr) else $error("group 0 write lost");

   property p_sec_g1_wr;
      @(posedge ref_clk) disable iff (sys_rst)
      s_sec_ctl_wr ##0 (VERSION_TWO || (SECURITY && V1_ALIAS_BIT1))
      |=> st.group1_forward_en == $past(hwdata[dgc_pkg::CTL_GRP1_BIT]);
   endproperty
   a_sec_g1_wr: assert property (p_sec_g1_wr) else $error("group 1 write lost");

   property p_lock_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      s_sec_ctl_wr ##0 (SECURITY && config_lock_in) |=> $stable(st.group0_forward_en);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked write landed");

   property p_ctl_rd_res;
      @(posedge ref_clk) disable iff (sys_rst)
      s_ctl_rd |-> hrdata[31:2] == 30'h0;
   endproperty
   a_ctl_rd_res: assert property (p_ctl_rd_res) else $error("reserved bits set");

   property p_ns_rd;
      @(posedge ref_clk) disable iff (sys_rst)
      s_ctl_rd ##0 st.ap.nonsec
      |-> hrdata[31:1] == 31'h0 && hrdata[0] == st.group1_forward_en;
   endproperty
   a_ns_rd: assert property (p_ns_rd) else $error("ns view wrong");

   property p_sec_rd;
      @(posedge ref_clk) disable iff (sys_rst)
      s_ctl_rd ##0 !st.ap.nonsec |-> hrdata[0] == st.group0_forward_en;
   endproperty
   a_sec_rd: assert property (p_sec_rd) else $error("group 0 view wrong");

   property p_wr_other;
      @(posedge ref_clk) disable iff (sys_rst)
      (st.ap.pend && st.ap.write && st.ap.addr != dgc_pkg::ADDR_FORWARDING_CONTROL)
      |=> $stable(st.group0_forward_en) && $stable(st.group1_forward_en);
   endproperty
   a_wr_other: assert property (p_wr_other) else $error("read-only write landed");

   // ************************************************************
   // reset and strap checks
   // ************************************************************
   property p_reset;
      @(posedge ref_clk)
      sys_rst |=> !st.group0_forward_en && !st.group1_forward_en &&
                  !fwd_out.valid && ack_spurious;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");

   property p_edge_strap;
      @(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> edge_sets_pending_when_off == EDGE_WHEN_OFF;
   endproperty
   a_edge_strap: assert property (p_edge_strap) else $error("edge strap wrong");

   property p_sgi_strap;
      @(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> sgi_sw_clear_allowed == VERSION_TWO;
   endproperty
   a_sgi_strap: assert property (p_sgi_strap) else $error("sgi strap wrong");

   property p_lines_strap;
      @(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> irq_line_blocks == LINE_BLOCKS;
   endproperty
   a_lines_strap: assert property (p_lines_strap) else $error("line strap wrong");

   // ************************************************************
   // forwarding checks
   // ************************************************************
   sequence s_cand_ok;
      top_cand.valid && top_cand.id < dgc_pkg::FIRST_SPECIAL_ID &&
      top_cand.id[9:5] <= LINE_BLOCKS;
   endsequence

   property p_fwd_pass;
      @(posedge ref_clk) disable iff (sys_rst)
      s_cand_ok ##0 ((SECURITY || VERSION_TWO) &&
                     (top_cand.group1 ? st.group1_forward_en : st.group0_forward_en))
      |=> fwd_out.valid && fwd_out.id == $past(top_cand.id) &&
          fwd_out.group1 == $past(top_cand.group1);
   endproperty
   a_fwd_pass: assert property (p_fwd_pass) else $error("candidate not forwarded");

   property p_fwd_range;
      @(posedge ref_clk) disable iff (sys_rst)
      fwd_out.valid |-> fwd_out.id[9:5] <= LINE_BLOCKS;
   endproperty
   a_fwd_range: assert property (p_fwd_range) else $error("id above line count");

   property p_special_in;
      @(posedge ref_clk) disable iff (sys_rst)
      top_cand.id >= dgc_pkg::FIRST_SPECIAL_ID |=> !fwd_out.valid;
   endproperty
   a_special_in: assert property (p_special_in) else $error("special id passed");

   property p_spur_off;
      @(posedge ref_clk) disable iff (sys_rst)
      fwd_out.valid |-> !ack_spurious;
   endproperty
   a_spur_off: assert property (p_spur_off) else $error("spurious with forward");
endmodule

// ===== shared/dgc_pkg.sv
// package: register map, field layout and shared types of the distributor global control block
package dgc_pkg;
   // ************************************************************
   // register map (byte addresses of aligned words)
   // ************************************************************
   localparam logic [11:0] ADDR_FORWARDING_CONTROL    = 12'h000;
   localparam logic [11:0] ADDR_CONTROLLER_TYPE_INFO  = 12'h004;
   localparam logic [11:0] ADDR_FORWARD_STATUS        = 12'h008;
   localparam int          ADDR_W                     = 12;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CTL_GRP0_BIT     = 0;
   localparam int CTL_GRP1_BIT     = 1;
   localparam int TYP_LINES_LSB    = 0;
   localparam int TYP_CPU_LSB      = 5;
   localparam int TYP_SEC_BIT      = 10;
   localparam int TYP_LOCK_LSB     = 11;
   localparam int ID_W             = 10;
   localparam logic [ID_W-1:0] SPURIOUS_ID     = 10'h3FF;
   localparam logic [ID_W-1:0] FIRST_SPECIAL_ID = 10'h3FC;
   localparam logic [ID_W-1:0] MAX_IRQ_ID      = 10'h3FB;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic CTL_RESET = 1'b0;

   // ************************************************************
   // ahb-lite encodings
   // ************************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // best pending candidate offered by the prioritiser
   typedef struct packed {
      logic            valid;
      logic            group1;
      logic [ID_W-1:0] id;
   } dgc_cand_t;

   // forwarded interrupt towards the cpu interfaces
   typedef struct packed {
      logic            valid;
      logic            group1;
      logic [ID_W-1:0] id;
   } dgc_fwd_t;

   // latched ahb address phase
   typedef struct packed {
      logic              pend;
      logic              write;
      logic              nonsec;
      logic [ADDR_W-1:0] addr;
   } dgc_aphase_t;

   typedef enum logic [1:0] {
      DGC_BUS_IDLE = 2'b00,
      DGC_BUS_DATA = 2'b01
   } dgc_bus_st_t;
endpackage

// ===== test/dgc_cpu_iface_model.sv
// cpu interface model: answers acknowledge reads from what the distributor forwards
`timescale 1ns/1ps
module dgc_cpu_iface_model (
   input  wire logic              ref_clk,
   input  wire dgc_pkg::dgc_fwd_t fwd_in,
   input  wire logic              spurious_in,
   output logic [9:0]             ack_id
);
   // ************************************************************
   // acknowledge path
   // ************************************************************
   // nothing forwardable gives the spurious id, never a stale id
   always_comb begin
      ack_id = (spurious_in || !fwd_in.valid) ? dgc_pkg::SPURIOUS_ID : fwd_in.id;
   end
endmodule

// ===== test/testbench.sv
// testbench: ahb-lite register checks and forwarding scenarios
`timescale 1ns/1ps
module testbench;
   logic                ref_clk, sys_rst, hsel, hwrite, hnonsec, hready, config_lock_in;
   logic [31:0]         haddr, hwdata, hrdata, rdv;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   logic [3:0]          hprot;
   logic                hreadyout, hresp, ack_spurious, edge_pend, sgi_clr;
   logic [4:0]          line_blocks;
   logic [9:0]          ack_id;
   dgc_pkg::dgc_cand_t  top_cand;
   dgc_pkg::dgc_fwd_t   fwd_out;
   int                  n_errors, check_count, cyc;
   // ************************************************************
   // design and far side
   // ************************************************************
   dgc_global_ctrl #(.VERSION_TWO(1'b1), .SECURITY(1'b1), .LOCKABLE_COUNT(5'h1F),
      .CPU_COUNT_M1(3'h3), .LINE_BLOCKS(5'h03), .EDGE_WHEN_OFF(1'b1)) uut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hnonsec(hnonsec), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .config_lock_in(config_lock_in), .top_cand(top_cand), .fwd_out(fwd_out),
      .ack_spurious(ack_spurious), .edge_sets_pending_when_off(edge_pend),
      .sgi_sw_clear_allowed(sgi_clr), .irq_line_blocks(line_blocks));
   dgc_cpu_iface_model cpu (.ref_clk(ref_clk), .fwd_in(fwd_out), .spurious_in(ack_spurious),
      .ack_id(ack_id));
   assign hready = hreadyout;
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // one single word transfer; waits on hready, data taken at the closing edge
   task automatic bus(input logic wr, input logic ns, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      haddr <= {20'h0, a};
      htrans <= dgc_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hnonsec <= ns;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic ns, input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, ns, a, d, rdv);
   endtask
   task automatic rd(input string nm, input logic ns, input logic [11:0] a,
                     input logic [31:0] e);
      bus(1'b0, ns, a, 32'h0, rdv);
      chk(nm, e, rdv);
      chk("resp", 32'h0, {31'h0, hresp});
   endtask
   // program the secure copy, offer one candidate, look two edges later
   task automatic fwd_case(input logic [1:0] ctl, input logic g1, input logic [9:0] id,
                           input logic ev);
      wr(1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, {30'h0, ctl});
      top_cand <= '{valid: 1'b1, group1: g1, id: id};
      repeat (2) @(posedge ref_clk);
      #1;
      chk("fwd_valid", {31'h0, ev}, {31'h0, fwd_out.valid});
      chk("spurious", {31'h0, !ev}, {31'h0, ack_spurious});
      chk("ack_id", {22'h0, ev ? id : dgc_pkg::SPURIOUS_ID}, {22'h0, ack_id});
      @(posedge ref_clk);
      top_cand <= '0;
   endtask
   // ************************************************************
   // hang guard
   // ************************************************************
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {sys_rst, hsel, hwrite, hnonsec, config_lock_in} = 5'b11000;
      {haddr, hwdata, htrans, hsize, hprot, top_cand} = '0;
      hsize = dgc_pkg::HSIZE_WORD;
      {n_errors, check_count, cyc} = '0;
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk("spur_rst", 32'h1, {31'h0, ack_spurious});
      chk("straps", 32'h63, {25'h0, edge_pend, sgi_clr, line_blocks});
      @(posedge ref_clk);
      rd("ctl_rst", 1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h0);
      rd("type", 1'b0, dgc_pkg::ADDR_CONTROLLER_TYPE_INFO, 32'hFC63);
      wr(1'b0, dgc_pkg::ADDR_CONTROLLER_TYPE_INFO, 32'h0);
      rd("type_ro", 1'b0, dgc_pkg::ADDR_CONTROLLER_TYPE_INFO, 32'hFC63);
      rd("unmapped", 1'b0, 12'h00C, 32'h0);
      wr(1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'hFFFFFFFF);
      rd("ctl_res", 1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h3);
      rd("ctl_ns", 1'b1, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h1);
      hprot <= 4'h8;
      rd("ctl_prot", 1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h1);
      hprot <= 4'h0;
      wr(1'b1, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h0);
      rd("ctl_ns_wi", 1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h1);
      hsel <= 1'b0;
      wr(1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h0);
      hsel <= 1'b1;
      rd("ctl_unsel", 1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h1);
      // secure group 0 enable frozen by lockdown, group 1 still writable
      wr(1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h1);
      config_lock_in <= 1'b1;
      wr(1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h2);
      rd("ctl_lock", 1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h3);
      config_lock_in <= 1'b0;
      fwd_case(2'h0, 1'b0, 10'h005, 1'b0);
      fwd_case(2'h3, 1'b0, 10'h005, 1'b1);
      fwd_case(2'h3, 1'b1, 10'h07F, 1'b1);
      fwd_case(2'h3, 1'b1, 10'h080, 1'b0);
      fwd_case(2'h3, 1'b0, 10'h3FC, 1'b0);
      fwd_case(2'h1, 1'b1, 10'h009, 1'b0);
      fwd_case(2'h2, 1'b0, 10'h009, 1'b0);
      fwd_case(2'h2, 1'b1, 10'h009, 1'b1);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd("ctl_rst2", 1'b0, dgc_pkg::ADDR_FORWARDING_CONTROL, 32'h0);
      tally_and_finish;
   end
endmodule
